// ===== dftl_loop.sv
// Dynamic fan turn-on threshold loop for two remote channels
`timescale 1ns/100ps
module dftl_loop (
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_reg_wr,
   input  wire logic [7:0]                    i_reg_addr,
   input  wire logic [7:0]                    i_reg_wdata,
   output logic      [7:0]                    o_reg_rdata,
   input  wire logic                          i_cycle_done,
   input  wire logic [dftl_pkg::TEMP_W-1:0]   i_temp_r1,
   input  wire logic [dftl_pkg::TEMP_W-1:0]   i_temp_r2,
   input  wire logic [7:0]                    i_low_limit_r1,
   input  wire logic [7:0]                    i_low_limit_r2,
   input  wire logic [7:0]                    i_high_limit_r1,
   input  wire logic [7:0]                    i_high_limit_r2,
   input  wire logic                          i_thermal_event_line_n,
   output logic      [7:0]                    o_fan_turn_on_threshold_r1,
   output logic      [7:0]                    o_fan_turn_on_threshold_r2,
   output logic      [7:0]                    o_operating_point_r1,
   output logic      [7:0]                    o_operating_point_r2,
   output logic      [1:0]                    o_below_threshold
);

   localparam int NCH = dftl_pkg::NCH;

   // Software registers
   logic [7:0] enables_q;
   logic [7:0] cycle_sel_q;
   logic [7:0] hyst_reg_q;
   logic [7:0] op_q        [NCH];
   logic [7:0] thr_q       [NCH];
   logic [7:0] thr_d       [NCH];
   logic [7:0] op_d        [NCH];

   // Per-channel views of the inputs
   logic [dftl_pkg::TEMP_W-1:0] temp     [NCH];
   logic [dftl_pkg::TEMP_W-1:0] prev_q   [NCH];
   logic [7:0]                  low_lim  [NCH];
   logic [7:0]                  high_lim [NCH];
   logic [dftl_pkg::CYC_W-1:0]  code     [NCH];
   logic [NCH-1:0]              short_hit;
   logic [NCH-1:0]              long_hit;
   logic [NCH-1:0]              below_d;

   // Thermal event synchroniser and edge detect
   logic ev_meta_q;
   logic ev_sync_q;
   logic ev_prev_q;
   logic ev_fall;

   // Register readback
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic [1:0] below_q;

   logic [dftl_pkg::HYST_W-1:0] hyst;

   // Write strobes, one per register
   logic           wr_enables;
   logic           wr_cycle_sel;
   logic           wr_hyst;
   logic [NCH-1:0] wr_op;
   logic [NCH-1:0] wr_thr;

   assign temp[0]     = i_temp_r1;
   assign temp[1]     = i_temp_r2;
   assign low_lim[0]  = i_low_limit_r1;
   assign low_lim[1]  = i_low_limit_r2;
   assign high_lim[0] = i_high_limit_r1;
   assign high_lim[1] = i_high_limit_r2;

   // Cycle-length codes, one field per channel
   assign code[0] = cycle_sel_q[dftl_pkg::CYC1_LSB +: dftl_pkg::CYC_W];
   assign code[1] = cycle_sel_q[dftl_pkg::CYC2_LSB +: dftl_pkg::CYC_W];
   assign hyst    = hyst_reg_q[dftl_pkg::HYST_LSB +: dftl_pkg::HYST_W];

   // Write strobe decode; unmapped writes raise no strobe
   always_comb begin
      wr_enables   = 1'b0;
      wr_cycle_sel = 1'b0;
      wr_hyst      = 1'b0;
      wr_op        = '0;
      wr_thr       = '0;
      if (i_reg_wr) begin
         if (i_reg_addr == dftl_pkg::ADDR_ENABLES) begin
            wr_enables = 1'b1;
         end else if (i_reg_addr == dftl_pkg::ADDR_CYCLE_SEL) begin
            wr_cycle_sel = 1'b1;
         end else if (i_reg_addr == dftl_pkg::ADDR_HYST) begin
            wr_hyst = 1'b1;
         end else if (i_reg_addr == dftl_pkg::ADDR_OP_R1) begin
            wr_op[0] = 1'b1;
         end else if (i_reg_addr == dftl_pkg::ADDR_OP_R2) begin
            wr_op[1] = 1'b1;
         end else if (i_reg_addr == dftl_pkg::ADDR_THR_R1) begin
            wr_thr[0] = 1'b1;
         end else if (i_reg_addr == dftl_pkg::ADDR_THR_R2) begin
            wr_thr[1] = 1'b1;
         end
      end
   end

   // One timer pair per channel
   for (genvar c = 0; c < NCH; c++) begin : g_timer
      dftl_cycle_timer u_timer (
         .i_clk       (i_clk),
         .i_rst_n     (i_rst_n),
         .i_code      (code[c]),
         .i_tick      (i_cycle_done),
         .o_short_hit (short_hit[c]),
         .o_long_hit  (long_hit[c])
      );
   end

   // Thermal line is a pin: two flops before anything looks at it
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ev_meta_q <= 1'b1;
         ev_sync_q <= 1'b1;
         ev_prev_q <= 1'b1;
      end else begin
         ev_meta_q <= i_thermal_event_line_n;
         ev_sync_q <= ev_meta_q;
         ev_prev_q <= ev_sync_q;
      end
   end

   // Capture only on the pull-low edge, so one event copies once
   assign ev_fall = ev_prev_q && !ev_sync_q;

   // Loop arithmetic: temperature compares in quarter degrees, threshold steps in degrees, signed to catch underflow
   always_comb begin
      logic signed [12:0] t_q;
      logic signed [12:0] p_q;
      logic signed [12:0] thr_qd;
      logic signed [12:0] op_qd;
      logic signed [12:0] zone_qd;
      logic signed [12:0] low_qd;
      logic signed [12:0] rise;
      logic signed [12:0] nxt;
      logic               active;
      logic               short_dn;
      logic               long_dn;
      logic               long_up;
      t_q     = '0;
      p_q     = '0;
      thr_qd  = '0;
      op_qd   = '0;
      zone_qd = '0;
      low_qd  = '0;
      rise    = '0;
      nxt     = '0;
      active  = 1'b0;
      short_dn = 1'b0;
      long_dn  = 1'b0;
      long_up  = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         t_q     = {3'b000, temp[c]};
         p_q     = {3'b000, prev_q[c]};
         thr_qd  = {3'b000, thr_q[c], 2'b00};
         op_qd   = {3'b000, op_q[c], 2'b00};
         low_qd  = {3'b000, low_lim[c], 2'b00};
         zone_qd = op_qd - {7'h00, hyst, 2'b00};
         rise    = t_q - p_q;
         nxt     = {5'h00, thr_q[c]};
         // Below threshold the loop sleeps; enable gates it too
         active  = enables_q[dftl_pkg::EN_LSB + c] && (t_q >= thr_qd);
         below_d[c] = (t_q < thr_qd);

         // Short cycle: lower by twice the rise once past the zone edge
         short_dn = short_hit[c] && active && (t_q > zone_qd)
                    && (rise > $signed({2'b00, dftl_pkg::RISE_MIN}));
         if (short_dn) begin
            nxt = nxt - (rise >>> 1);
         end

         // Long cycle: one degree down only past the operating point
         long_dn = long_hit[c] && active && (t_q > op_qd);
         if (long_dn) begin
            nxt = nxt - $signed({1'b0, dftl_pkg::LONG_STEP});
         end

         // Long cycle raise needs all four conditions
         long_up = long_hit[c] && active && (t_q < low_qd)
                   && (thr_q[c] < high_lim[c])
                   && (thr_q[c] < op_q[c]) && (t_q > thr_qd);
         if (long_up) begin
            nxt = nxt + $signed({1'b0, dftl_pkg::LONG_STEP});
         end
         // Between low limit and zone edge nothing above fires

         // Floor at minus 64 degrees
         if (nxt < $signed({5'h00, dftl_pkg::THR_FLOOR})) begin
            nxt = {5'h00, dftl_pkg::THR_FLOOR};
         end
         thr_d[c] = nxt[7:0];
      end
   end

   // Operating point next value: thermal capture beats a write
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         op_d[c] = op_q[c];
         if (wr_op[c]) begin
            op_d[c] = i_reg_wdata;
         end
         if (ev_fall && enables_q[dftl_pkg::CAP_LSB + c]) begin
            op_d[c] = temp[c][dftl_pkg::TEMP_W-1:dftl_pkg::FRAC_W];
         end
      end
   end

   // Control registers written by software
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enables_q   <= dftl_pkg::RST_ENABLES;
         cycle_sel_q <= dftl_pkg::RST_CYCLE_SEL;
         hyst_reg_q  <= dftl_pkg::RST_HYST;
      end else begin
         if (wr_enables) begin
            enables_q <= i_reg_wdata;
         end else if (wr_cycle_sel) begin
            cycle_sel_q <= i_reg_wdata;
         end else if (wr_hyst) begin
            hyst_reg_q <= i_reg_wdata;
         end
      end
   end

   // Operating points per channel
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int c = 0; c < NCH; c++) begin
            op_q[c] <= dftl_pkg::RST_OP;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            op_q[c] <= op_d[c];
         end
      end
   end

   // Thresholds: a software write overrides the loop in that cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int c = 0; c < NCH; c++) begin
            thr_q[c] <= dftl_pkg::RST_THR;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (wr_thr[c]) begin
               thr_q[c] <= i_reg_wdata;
            end else begin
               thr_q[c] <= thr_d[c];
            end
         end
      end
   end

   // Last monitoring cycle's temperature, for the rise figure
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int c = 0; c < NCH; c++) begin
            prev_q[c] <= '0;
         end
      end else if (i_cycle_done) begin
         for (int c = 0; c < NCH; c++) begin
            prev_q[c] <= temp[c];
         end
      end
   end

   // Readback decode; holes read zero
   always_comb begin
      if (i_reg_addr == dftl_pkg::ADDR_ENABLES) begin
         rdata_d = enables_q;
      end else if (i_reg_addr == dftl_pkg::ADDR_CYCLE_SEL) begin
         rdata_d = cycle_sel_q;
      end else if (i_reg_addr == dftl_pkg::ADDR_OP_R1) begin
         rdata_d = op_q[0];
      end else if (i_reg_addr == dftl_pkg::ADDR_OP_R2) begin
         rdata_d = op_q[1];
      end else if (i_reg_addr == dftl_pkg::ADDR_HYST) begin
         rdata_d = hyst_reg_q;
      end else if (i_reg_addr == dftl_pkg::ADDR_THR_R1) begin
         rdata_d = thr_q[0];
      end else if (i_reg_addr == dftl_pkg::ADDR_THR_R2) begin
         rdata_d = thr_q[1];
      end else begin
         rdata_d = dftl_pkg::RD_UNMAPPED;
      end
   end

   // Registered read data and fan-minimum flags
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= '0;
         below_q <= '0;
      end else begin
         rdata_q <= rdata_d;
         below_q <= below_d;
      end
   end

   assign o_reg_rdata                = rdata_q;
   assign o_fan_turn_on_threshold_r1 = thr_q[0];
   assign o_fan_turn_on_threshold_r2 = thr_q[1];
   assign o_operating_point_r1       = op_q[0];
   assign o_operating_point_r2       = op_q[1];
   assign o_below_threshold          = below_q;

endmodule // dftl_loop

// ===== dftl_pkg.sv
// Constants, register map and field layout for the dynamic fan threshold loop
package dftl_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_ENABLES   = 8'h0b;
   localparam logic [7:0] ADDR_CYCLE_SEL = 8'h0c;
   localparam logic [7:0] ADDR_OP_R1     = 8'h5a;
   localparam logic [7:0] ADDR_OP_R2     = 8'h5b;
   localparam logic [7:0] ADDR_HYST      = 8'h64;
   localparam logic [7:0] ADDR_THR_R1    = 8'h70;
   localparam logic [7:0] ADDR_THR_R2    = 8'h71;

   // Reset values
   localparam logic [7:0] RST_ENABLES    = 8'h00;
   localparam logic [7:0] RST_CYCLE_SEL  = 8'h00;
   localparam logic [7:0] RST_OP         = 8'ha4;
   localparam logic [7:0] RST_HYST       = 8'h40;
   localparam logic [7:0] RST_THR        = 8'h80;
   localparam logic [7:0] RD_UNMAPPED    = 8'h00;

   // Field positions
   localparam int NCH       = 2;
   localparam int EN_LSB    = 0;
   localparam int CAP_LSB   = 2;
   localparam int CYC_W     = 3;
   localparam int CYC1_LSB  = 0;
   localparam int CYC2_LSB  = 3;
   localparam int HYST_LSB  = 4;
   localparam int HYST_W    = 4;

   // Temperatures: offset-64 degrees, two fraction bits (quarters)
   localparam int TEMP_W    = 10;
   localparam int FRAC_W    = 2;
   localparam logic [7:0] THR_FLOOR = 8'h00;

   // Loop step sizes
   localparam logic [10:0] RISE_MIN  = 11'h001;
   localparam logic [11:0] LONG_STEP = 12'h001;

   // Cycle counter layout
   localparam int CNT_W                = 12;
   localparam logic [11:0] SHORT_BASE  = 12'h008;

endpackage : dftl_pkg

// ===== dftl_cycle_timer.sv
// Short and long cycle counters for one channel
`timescale 1ns/100ps
module dftl_cycle_timer (
   input  wire logic                           i_clk,
   input  wire logic                           i_rst_n,
   input  wire logic [dftl_pkg::CYC_W-1:0]     i_code,
   input  wire logic                           i_tick,
   output logic                                o_short_hit,
   output logic                                o_long_hit
);

   logic [dftl_pkg::CNT_W-1:0] short_cnt_q;
   logic [dftl_pkg::CNT_W-1:0] long_cnt_q;
   logic [dftl_pkg::CNT_W-1:0] short_last;
   logic [dftl_pkg::CNT_W-1:0] long_last;

   // Period from code: 8 doubling per step, long twice short
   // Long doubles by a second shift; code plus one would wrap at 111
   assign short_last  = (dftl_pkg::SHORT_BASE << i_code) - 12'h001;
   assign long_last   = ((dftl_pkg::SHORT_BASE << i_code) << 1) - 12'h001;
   // At-or-beyond compare so a shortened code cannot strand a counter
   assign o_short_hit = i_tick && (short_cnt_q >= short_last);
   assign o_long_hit  = i_tick && (long_cnt_q >= long_last);

   // Short counter, one step per monitoring cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         short_cnt_q <= '0;
      end else if (o_short_hit) begin
         short_cnt_q <= '0;
      end else if (i_tick) begin
         short_cnt_q <= short_cnt_q + 12'h001;
      end
   end

   // Long counter runs apart from the short one
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         long_cnt_q <= '0;
      end else if (o_long_hit) begin
         long_cnt_q <= '0;
      end else if (i_tick) begin
         long_cnt_q <= long_cnt_q + 12'h001;
      end
   end

endmodule // dftl_cycle_timer

// ===== dftl_loop_chk.sv
// Concurrent checks on the first channel of the threshold loop
`timescale 1ns/100ps
module dftl_loop_chk (
   input wire logic                        i_clk,
   input wire logic                        i_rst_n,
   input wire logic                        i_reg_wr,
   input wire logic [7:0]                  i_reg_addr,
   input wire logic [7:0]                  i_reg_wdata,
   input wire logic [7:0]                  o_reg_rdata,
   input wire logic                        i_cycle_done,
   input wire logic [dftl_pkg::TEMP_W-1:0] i_temp_r1,
   input wire logic [7:0]                  i_high_limit_r1,
   input wire logic [7:0]                  o_fan_turn_on_threshold_r1,
   input wire logic [1:0]                  o_below_threshold
);
   logic       en1_q;
   logic       wr_thr;
   logic [7:0] thr;
   assign wr_thr = i_reg_wr && (i_reg_addr == dftl_pkg::ADDR_THR_R1);
   assign thr    = o_fan_turn_on_threshold_r1;
   // Shadow of enable bit 0, since the checker cannot see the register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) en1_q <= 1'b0;
      else if (i_reg_wr && i_reg_addr == dftl_pkg::ADDR_ENABLES) en1_q <= i_reg_wdata[0];
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Steps of a threshold update: a write, or a quiet cycle
   sequence s_thr_write; wr_thr; endsequence
   sequence s_quiet; !wr_thr && !i_cycle_done; endsequence
   a_write_takes_effect: assert property (
      s_thr_write |=> thr == $past(i_reg_wdata)) else $error("threshold write lost");
   a_hold_between_pulses: assert property (
      s_quiet |=> $stable(thr)) else $error("threshold moved without a cycle pulse");
   a_disabled_holds: assert property (
      !en1_q && !wr_thr |=> $stable(thr)) else $error("threshold moved while disabled");
   a_below_no_adjust: assert property (
      i_temp_r1 < {thr, 2'b00} && !wr_thr |=> $stable(thr)) else $error("moved below threshold");
   a_raise_one_step: assert property (
      !wr_thr |=> {1'b0, thr} <= {1'b0, $past(thr)} + 9'h001) else $error("raise above one step");
   a_raise_below_high: assert property (
      !wr_thr ##1 thr > $past(thr) |-> $past(thr) < $past(i_high_limit_r1))
      else $error("raise at or above high limit");
   a_below_flag: assert property (
      i_rst_n |=> o_below_threshold[0] == ($past(i_temp_r1) < {$past(thr), 2'b00}))
      else $error("below flag wrong");
   a_rdata_thr: assert property (
      i_reg_addr == dftl_pkg::ADDR_THR_R1 |=> o_reg_rdata == $past(thr))
      else $error("threshold readback wrong");
endmodule // dftl_loop_chk
bind dftl_loop dftl_loop_chk u_chk (.i_clk, .i_rst_n, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
   .o_reg_rdata, .i_cycle_done, .i_temp_r1, .i_high_limit_r1, .o_fan_turn_on_threshold_r1,
   .o_below_threshold);

// ===== tb.sv
// Self-checking testbench for the dynamic fan threshold loop
`timescale 1ns/100ps
module tb;
   logic       i_clk, i_rst_n, i_reg_wr, i_cycle_done, i_thermal_event_line_n;
   logic [7:0] i_reg_addr, i_reg_wdata, lo1, lo2, hi1, hi2;
   logic [9:0] t1, t2;
   logic [7:0] rdata, thr1, thr2, op1, op2;
   logic [1:0] below;
   int         num_errors, num_checks;
   int         cyc = 0;

   dftl_loop u_dftl_loop (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata),
      .i_cycle_done(i_cycle_done), .i_temp_r1(t1), .i_temp_r2(t2), .i_low_limit_r1(lo1),
      .i_low_limit_r2(lo2), .i_high_limit_r1(hi1), .i_high_limit_r2(hi2),
      .i_thermal_event_line_n(i_thermal_event_line_n), .o_fan_turn_on_threshold_r1(thr1),
      .o_fan_turn_on_threshold_r2(thr2), .o_operating_point_r1(op1),
      .o_operating_point_r2(op2), .o_below_threshold(below));

   // 10 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         num_errors++;
         results();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask

   // Read data is registered, so it is taken one edge after the address
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_reg_addr <= a;
      @(posedge i_clk);
      @(negedge i_clk);
      chk(rdata, exp);
   endtask

   // Monitoring pulses, one idle cycle apart; pulse number at carries a new temperature
   task automatic pulses(input int n, input int at, input logic [9:0] tn);
      for (int i = 1; i <= n; i++) begin
         @(posedge i_clk);
         i_cycle_done <= 1'b1;
         if (i == at) t1 <= tn;
         @(posedge i_clk);
         i_cycle_done <= 1'b0;
      end
      @(negedge i_clk);
   endtask

   task automatic setup(input logic [7:0] en, thr, op, lo, hi, input logic [9:0] t);
      wr(dftl_pkg::ADDR_ENABLES, en);
      wr(dftl_pkg::ADDR_THR_R1, thr);
      wr(dftl_pkg::ADDR_OP_R1, op);
      @(posedge i_clk);
      lo1 <= lo;
      hi1 <= hi;
      t1 <= t;
   endtask

   task automatic t_reset();
      logic [7:0] a[8] = '{8'h0b, 8'h0c, 8'h5a, 8'h5b, 8'h64, 8'h70, 8'h71, 8'h01};
      logic [7:0] e[8] = '{8'h00, 8'h00, 8'ha4, 8'ha4, 8'h40, 8'h80, 8'h80, 8'h00};
      for (int i = 0; i < 8; i++) rd(a[i], e[i]);
      $display("reset values test done");
   endtask

   task automatic t_short();
      setup(8'h01, 8'h50, 8'h60, 8'h00, 8'hff, {8'h5d, 2'b00});
      pulses(7, 0, 10'h000);
      chk(thr1, 8'h50);
      pulses(1, 1, {8'h5e, 2'b00});
      chk(thr1, 8'h4e);
      pulses(8, 0, 10'h000);
      chk(thr1, 8'h4e);
      $display("short cycle test done");
   endtask

   task automatic t_small_rise();
      setup(8'h01, 8'h50, 8'h60, 8'h00, 8'hff, {8'h5d, 2'b00});
      pulses(16, 8, {8'h5d, 2'b01});
      chk(thr1, 8'h50);
      $display("small rise test done");
   endtask

   // Above the operating point both cycles lower the threshold together
   task automatic t_long();
      setup(8'h01, 8'h50, 8'h60, 8'h00, 8'hff, {8'h62, 2'b00});
      pulses(16, 16, {8'h63, 2'b00});
      chk(thr1, 8'h4d);
      $display("long cycle test done");
   endtask

   task automatic t_raise();
      setup(8'h01, 8'h30, 8'h60, 8'h40, 8'h70, {8'h38, 2'b00});
      pulses(16, 0, 10'h000);
      chk(thr1, 8'h31);
      pulses(16, 1, {8'h48, 2'b00});
      chk(thr1, 8'h31);
      setup(8'h01, 8'h31, 8'h60, 8'h40, 8'h31, {8'h38, 2'b00});
      pulses(16, 0, 10'h000);
      chk(thr1, 8'h31);
      $display("raise test done");
   endtask

   task automatic t_floor();
      setup(8'h01, 8'h00, 8'h00, 8'h00, 8'hff, {8'h01, 2'b00});
      pulses(16, 0, 10'h000);
      chk(thr1, 8'h00);
      $display("floor test done");
   endtask

   task automatic t_below();
      setup(8'h01, 8'h50, 8'h30, 8'h00, 8'hff, {8'h40, 2'b00});
      pulses(16, 8, {8'h42, 2'b00});
      chk(thr1, 8'h50);
      chk({6'h00, below}, 8'h03);
      $display("below threshold test done");
   endtask

   task automatic t_disabled();
      setup(8'h00, 8'h50, 8'h30, 8'h00, 8'hff, {8'h60, 2'b00});
      pulses(16, 8, {8'h62, 2'b00});
      chk(thr1, 8'h50);
      rd(dftl_pkg::ADDR_ENABLES, 8'h00);
      $display("disabled test done");
   endtask

   // Second channel on code 1: nothing at 16 pulses, one long step at 32
   task automatic t_ch2();
      wr(dftl_pkg::ADDR_CYCLE_SEL, 8'h08);
      wr(dftl_pkg::ADDR_ENABLES, 8'h02);
      wr(dftl_pkg::ADDR_THR_R2, 8'h50);
      wr(dftl_pkg::ADDR_OP_R2, 8'h60);
      t2 <= {8'h62, 2'b00};
      pulses(16, 0, 10'h000);
      chk(thr2, 8'h50);
      pulses(16, 0, 10'h000);
      chk(thr2, 8'h4f);
      rd(dftl_pkg::ADDR_CYCLE_SEL, 8'h08);
      wr(dftl_pkg::ADDR_CYCLE_SEL, 8'h00);
      $display("second channel test done");
   endtask

   // Capture enabled on channel one only; the pin passes a synchroniser first
   task automatic t_thermal_event_line();
      wr(dftl_pkg::ADDR_ENABLES, 8'h04);
      t1 <= {8'h77, 2'b00};
      t2 <= {8'h22, 2'b00};
      i_thermal_event_line_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      chk(op1, 8'h77);
      chk(op2, 8'h60);
      @(posedge i_clk);
      i_thermal_event_line_n <= 1'b1;
      $display("thermal capture test done");
   endtask

   initial begin
      {num_errors, num_checks} = '0;
      {i_reg_wr, i_cycle_done, i_reg_addr, i_reg_wdata, lo1, lo2} = '0;
      {hi1, hi2, t1, t2} = {8'hff, 8'hff, 10'h000, 10'h000};
      i_thermal_event_line_n = 1'b1;
      i_rst_n = 1'b0;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_short();
      t_small_rise();
      t_long();
      t_raise();
      t_floor();
      t_below();
      t_disabled();
      t_ch2();
      t_thermal_event_line();
      results();
   end
endmodule // tb
